// ===== sio_pkg.sv
// Package: register map, field positions, reset values and timing counts of the serial port
package sio_pkg;

  // ------------------------------------------------------------
  // Register byte offsets (Avalon-MM, one aligned word each)
  // ------------------------------------------------------------
  localparam logic [5:0] OFF_RX_STATUS = 6'h00;
  localparam logic [5:0] OFF_RX_DATA = 6'h04;
  localparam logic [5:0] OFF_TX_STATUS = 6'h08;
  localparam logic [5:0] OFF_TX_DATA = 6'h0C;
  localparam logic [5:0] OFF_BAUD_LOW = 6'h10;
  localparam logic [5:0] OFF_BAUD_HIGH = 6'h14;
  localparam logic [5:0] OFF_BAUD_CTRL = 6'h18;
  localparam logic [5:0] OFF_FLAGS = 6'h1C;
  localparam logic [5:0] OFF_IRQ_EN = 6'h20;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  // rx_status_reg
  localparam int RS_PORT_ENABLE = 7;
  localparam int RS_RX_NINE_BIT = 6;
  localparam int RS_SINGLE_RX = 5;
  localparam int RS_CONT_RX = 4;
  localparam int RS_ADDR_DETECT = 3;
  localparam int RS_FRAMING_ERR = 2;
  localparam int RS_OVERRUN_ERR = 1;
  localparam int RS_NINTH_DATA = 0;
  // tx_status_reg
  localparam int TS_CLOCK_SRC_MASTER = 7;
  localparam int TS_TX_NINE_BIT = 6;
  localparam int TS_TX_ENABLE = 5;
  localparam int TS_SYNC_SELECT = 4;
  localparam int TS_SHIFT_EMPTY = 1;
  localparam int TS_TX_NINTH_DATA = 0;
  // baud control
  localparam int BC_WIDE_DIVIDER = 3;
  localparam int BC_HIGH_SPEED = 1;
  localparam int BC_RX_POLARITY = 0;
  // flags and irq enables
  localparam int FL_RX_FLAG = 0;
  localparam int FL_TX_FLAG = 1;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_CTRL_BYTE = 8'h00;
  localparam logic RST_LINE_LEVEL = 1'b1;

  // ------------------------------------------------------------
  // Timing counts
  // ------------------------------------------------------------
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;  // x16 sample ticks per bit
  localparam logic [3:0] HALF_BIT_LAST = 4'h7;    // start bit checked mid-bit
  localparam logic [1:0] PRESCALE_SLOW = 2'h3;    // /4 per tick, /64 per bit
  localparam logic [1:0] PRESCALE_FAST = 2'h0;    // /1 per tick, /16 per bit
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

endpackage : sio_pkg

// ===== sio_pin_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sio_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] async_in, // Pin levels
  output logic [WIDTH-1:0] sync_out // Synchronised levels
);
  import sio_pkg::*;

  logic [WIDTH-1:0] meta_ff;

  // High at reset, the receive line's idle level, so rx_pin shows no false edge on release
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (!rstn) begin
        meta_ff[i] <= RST_LINE_LEVEL;
        sync_out[i] <= RST_LINE_LEVEL;
      end else begin
        meta_ff[i] <= async_in[i];
        sync_out[i] <= meta_ff[i];
      end
    end
  end

endmodule : sio_pin_sync

// ===== sio_rx_fifo.sv
// Small receive FIFO built from registers
`timescale 1ns/1ps
module sio_rx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic push, // Write one entry
  input wire logic [WIDTH-1:0] push_data, // Entry to write
  input wire logic pop, // Drop head entry
  output logic [WIDTH-1:0] head_data, // Head entry, from storage flops
  output logic empty, // No entry held
  output logic full // All entries held
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] count_ff;
  logic do_push;
  logic do_pop;

  assign empty = (count_ff == '0);
  assign full = (count_ff == DEPTH_CNT);
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign head_data = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= push_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= (wr_ptr_ff == PTR_LAST) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PTR_LAST) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (do_pop && !do_push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule : sio_rx_fifo

// ===== sio_serial_port.sv
// Serial port: asynchronous receiver with two-deep FIFO and synchronous slave transmitter
// ------------------------------------------------------------
// Overview of operation
// ------------------------------------------------------------
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module sio_serial_port (
  input wire logic clk, // System clock, 20 MHz
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [5:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read request
  input wire logic avs_write, // Avalon write request
  input wire logic [31:0] avs_writedata, // Avalon write data
  input wire logic [3:0] avs_byteenable, // Avalon byte enables
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait request
  input wire logic rx_pin, // Asynchronous receive line
  input wire logic shift_clock_pin, // External shift clock in slave mode
  output logic tx_data_out, // Synchronous transmit data
  output logic tx_data_oe, // Transmit data pin drive enable
  output logic irq_req, // Peripheral interrupt request
  output logic wake_req // Wake request from transmit flag
);
  import sio_pkg::*;
  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  logic port_enable_ff, rx_nine_bit_ff, single_rx_enable_ff, cont_rx_enable_ff, addr_detect_enable_ff;
  logic clock_source_master_ff, tx_nine_bit_ff, tx_enable_ff, sync_select_ff, tx_ninth_data_ff;
  logic wide_divider_sel_ff, high_speed_sel_ff, rx_polarity_invert_ff, rx_irq_enable_ff, tx_irq_enable_ff;
  logic [7:0] baud_div_low_ff, baud_div_high_ff;
  logic [31:0] readdata_ff, rd_mux;
  logic rd_pend_ff, wr_byte0, rd_accept, rx_pop, tx_write;
  // Receive side state
  logic [1:0] line_sync, pre_cnt_ff, pre_lim;
  logic rx_line, rx_prev_ff, rx_allowed, tick16, rx_done, rx_framing_error, rx_keep, overrun_error_ff;
  rx_state_e rx_state_ff;
  logic [3:0] tick_cnt_ff, bit_cnt_ff, rx_bits;
  logic [8:0] rx_shift_reg_ff, rx_assembled;
  logic [15:0] div_cnt_ff, div_val;
  logic [9:0] fifo_head;
  logic fifo_empty, fifo_full, rx_flag;
  // Transmit side state
  logic sck_s, sck_prev_ff, sck_fall, tx_slave, tx_hold_full_ff, tx_load, tx_flag, tx_out_ff;
  logic [7:0] tx_data_reg_ff;
  logic [8:0] tx_shift_reg_ff;
  logic [3:0] tx_left_ff;
  // ------------------------------------------------------------
  // Avalon-MM slave
  // ------------------------------------------------------------
  // Reads take one wait cycle so read data always come from a flop
  assign avs_waitrequest = avs_read & ~rd_pend_ff;
  assign rd_accept = avs_read & rd_pend_ff;
  assign avs_readdata = readdata_ff;
  assign wr_byte0 = avs_write & avs_byteenable[0];
  assign rx_pop = rd_accept & (avs_address == OFF_RX_DATA);
  assign tx_write = wr_byte0 & (avs_address == OFF_TX_DATA);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_pend_ff <= 1'b0;
      readdata_ff <= 32'h00000000;
    end else begin
      rd_pend_ff <= avs_read & ~rd_pend_ff;
      if (avs_read && !rd_pend_ff) begin
        readdata_ff <= rd_mux;
      end
    end
  end
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (avs_address)
      OFF_RX_STATUS: begin
        rd_mux[RS_PORT_ENABLE] = port_enable_ff;
        rd_mux[RS_RX_NINE_BIT] = rx_nine_bit_ff;
        rd_mux[RS_SINGLE_RX] = single_rx_enable_ff;
        rd_mux[RS_CONT_RX] = cont_rx_enable_ff;
        rd_mux[RS_ADDR_DETECT] = addr_detect_enable_ff;
        rd_mux[RS_FRAMING_ERR] = ~fifo_empty & fifo_head[9];
        rd_mux[RS_OVERRUN_ERR] = overrun_error_ff;
        rd_mux[RS_NINTH_DATA] = ~fifo_empty & fifo_head[8];
      end
      OFF_RX_DATA: rd_mux[7:0] = fifo_empty ? 8'h00 : fifo_head[7:0];
      OFF_TX_STATUS: begin
        rd_mux[TS_CLOCK_SRC_MASTER] = clock_source_master_ff;
        rd_mux[TS_TX_NINE_BIT] = tx_nine_bit_ff;
        rd_mux[TS_TX_ENABLE] = tx_enable_ff;
        rd_mux[TS_SYNC_SELECT] = sync_select_ff;
        rd_mux[TS_SHIFT_EMPTY] = (tx_left_ff == 4'h0);
        rd_mux[TS_TX_NINTH_DATA] = tx_ninth_data_ff;
      end
      OFF_BAUD_LOW: rd_mux[7:0] = baud_div_low_ff;
      OFF_BAUD_HIGH: rd_mux[7:0] = baud_div_high_ff;
      OFF_BAUD_CTRL: begin
        rd_mux[BC_WIDE_DIVIDER] = wide_divider_sel_ff;
        rd_mux[BC_HIGH_SPEED] = high_speed_sel_ff;
        rd_mux[BC_RX_POLARITY] = rx_polarity_invert_ff;
      end
      OFF_FLAGS: begin
        rd_mux[FL_RX_FLAG] = rx_flag;
        rd_mux[FL_TX_FLAG] = tx_flag;
      end
      OFF_IRQ_EN: begin
        rd_mux[FL_RX_FLAG] = rx_irq_enable_ff;
        rd_mux[FL_TX_FLAG] = tx_irq_enable_ff;
      end
      default: rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {port_enable_ff, rx_nine_bit_ff, single_rx_enable_ff, cont_rx_enable_ff, addr_detect_enable_ff} <= 5'h00;
      {clock_source_master_ff, tx_nine_bit_ff, tx_enable_ff, sync_select_ff, tx_ninth_data_ff} <= 5'h00;
      {wide_divider_sel_ff, high_speed_sel_ff, rx_polarity_invert_ff} <= 3'h0;
      {rx_irq_enable_ff, tx_irq_enable_ff} <= 2'h0;
      baud_div_low_ff <= RST_CTRL_BYTE;
      baud_div_high_ff <= RST_CTRL_BYTE;
    end else if (wr_byte0) begin
      unique case (avs_address)
        OFF_RX_STATUS: begin
          port_enable_ff <= avs_writedata[RS_PORT_ENABLE];
          rx_nine_bit_ff <= avs_writedata[RS_RX_NINE_BIT];
          single_rx_enable_ff <= avs_writedata[RS_SINGLE_RX];
          cont_rx_enable_ff <= avs_writedata[RS_CONT_RX];
          addr_detect_enable_ff <= avs_writedata[RS_ADDR_DETECT];
        end
        OFF_TX_STATUS: begin
          clock_source_master_ff <= avs_writedata[TS_CLOCK_SRC_MASTER];
          tx_nine_bit_ff <= avs_writedata[TS_TX_NINE_BIT];
          tx_enable_ff <= avs_writedata[TS_TX_ENABLE];
          sync_select_ff <= avs_writedata[TS_SYNC_SELECT];
          tx_ninth_data_ff <= avs_writedata[TS_TX_NINTH_DATA];
        end
        OFF_BAUD_LOW: baud_div_low_ff <= avs_writedata[7:0];
        OFF_BAUD_HIGH: baud_div_high_ff <= avs_writedata[7:0];
        OFF_BAUD_CTRL: begin
          wide_divider_sel_ff <= avs_writedata[BC_WIDE_DIVIDER];
          high_speed_sel_ff <= avs_writedata[BC_HIGH_SPEED];
          rx_polarity_invert_ff <= avs_writedata[BC_RX_POLARITY];
        end
        OFF_IRQ_EN: begin
          rx_irq_enable_ff <= avs_writedata[FL_RX_FLAG];
          tx_irq_enable_ff <= avs_writedata[FL_TX_FLAG];
        end
        default: ;
      endcase
    end
  end
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  sio_pin_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in({shift_clock_pin, rx_pin}),
    .sync_out(line_sync)
  );
  assign rx_line = line_sync[0] ^ rx_polarity_invert_ff;
  assign sck_s = line_sync[1];
  // ------------------------------------------------------------
  // Baud tick generator
  // ------------------------------------------------------------
  // Both fast selections use /1; one clock per x16 tick is the shortest available, with a fast selection and a divider of 0
  assign div_val = wide_divider_sel_ff ? {baud_div_high_ff, baud_div_low_ff} : {8'h00, baud_div_low_ff};
  assign pre_lim = (high_speed_sel_ff | wide_divider_sel_ff) ? PRESCALE_FAST : PRESCALE_SLOW;
  assign tick16 = (pre_cnt_ff == pre_lim) && (div_cnt_ff == div_val);
  // Restarted on every start edge so samples sit in phase with the character
  always_ff @(posedge clk) begin
    if (!rstn || rx_state_ff == RX_IDLE) begin
      pre_cnt_ff <= 2'h0;
      div_cnt_ff <= 16'h0000;
    end else if (pre_cnt_ff != pre_lim) begin
      pre_cnt_ff <= pre_cnt_ff + 2'h1;
    end else begin
      pre_cnt_ff <= 2'h0;
      div_cnt_ff <= (div_cnt_ff == div_val) ? 16'h0000 : div_cnt_ff + 16'h0001;
    end
  end
  // ------------------------------------------------------------
  // Receive framing
  // ------------------------------------------------------------
  assign rx_allowed = port_enable_ff & ~sync_select_ff & cont_rx_enable_ff & ~overrun_error_ff;
  assign rx_bits = rx_nine_bit_ff ? BITS_NINE : BITS_EIGHT;
  assign rx_assembled = rx_nine_bit_ff ? rx_shift_reg_ff : {1'b0, rx_shift_reg_ff[8:1]};
  assign rx_done = (rx_state_ff == RX_STOP) && tick16 && (tick_cnt_ff == OVERSAMPLE_LAST);
  assign rx_framing_error = ~rx_line;
  // In nine-bit mode, address detect drops characters whose ninth bit is clear
  assign rx_keep = ~(addr_detect_enable_ff & rx_nine_bit_ff & ~rx_assembled[8]);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_prev_ff <= RST_LINE_LEVEL;
      rx_state_ff <= RX_IDLE;
      tick_cnt_ff <= 4'h0;
      bit_cnt_ff <= 4'h0;
      rx_shift_reg_ff <= 9'h000;
    end else begin
      rx_prev_ff <= rx_line;
      if (!rx_allowed) begin
        rx_state_ff <= RX_IDLE;
      end else begin
        unique case (rx_state_ff)
          RX_IDLE: begin
            tick_cnt_ff <= 4'h0;
            if (rx_prev_ff && !rx_line) begin
              rx_state_ff <= RX_START;
            end
          end
          RX_START: if (tick16) begin
            if (tick_cnt_ff == HALF_BIT_LAST) begin
              tick_cnt_ff <= 4'h0;
              bit_cnt_ff <= 4'h0;
              rx_state_ff <= rx_line ? RX_IDLE : RX_DATA; // Glitch rejected mid-start
            end else begin
              tick_cnt_ff <= tick_cnt_ff + 4'h1;
            end
          end
          RX_DATA: if (tick16) begin
            if (tick_cnt_ff == OVERSAMPLE_LAST) begin
              tick_cnt_ff <= 4'h0;
              rx_shift_reg_ff <= {rx_line, rx_shift_reg_ff[8:1]};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              if (bit_cnt_ff == rx_bits - 4'h1) begin
                rx_state_ff <= RX_STOP;
              end
            end else begin
              tick_cnt_ff <= tick_cnt_ff + 4'h1;
            end
          end
          RX_STOP: if (tick16) begin
            tick_cnt_ff <= tick_cnt_ff + 4'h1;
            if (tick_cnt_ff == OVERSAMPLE_LAST) begin
              rx_state_ff <= RX_IDLE;
            end
          end
        endcase
      end
    end
  end
  // Set wins over the clear; the enable must be dropped to leave overrun
  always_ff @(posedge clk) begin
    if (!rstn) begin
      overrun_error_ff <= 1'b0;
    end else if (rx_done && rx_keep && fifo_full) begin
      overrun_error_ff <= 1'b1;
    end else if (!cont_rx_enable_ff) begin
      overrun_error_ff <= 1'b0;
    end
  end
  sio_rx_fifo #(.WIDTH(10), .DEPTH(2)) u_rx_fifo (
    .clk(clk),
    .rstn(rstn),
    .push(rx_done & rx_keep & ~fifo_full),
    .push_data({rx_framing_error, rx_assembled}),
    .pop(rx_pop),
    .head_data(fifo_head),
    .empty(fifo_empty),
    .full(fifo_full)
  );
  assign rx_flag = ~fifo_empty;
  // ------------------------------------------------------------
  // Synchronous slave transmitter
  // ------------------------------------------------------------
  // Shifts on falling edges of the external shift clock, detected through the synchroniser on the system clock
  assign tx_slave = port_enable_ff & sync_select_ff & ~clock_source_master_ff & tx_enable_ff;
  assign sck_fall = sck_prev_ff & ~sck_s;
  assign tx_load = tx_slave & tx_hold_full_ff & (tx_left_ff == 4'h0);
  assign tx_flag = ~tx_hold_full_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_data_reg_ff <= 8'h00;
      tx_hold_full_ff <= 1'b0;
    end else if (tx_write) begin
      tx_data_reg_ff <= avs_writedata[7:0];
      tx_hold_full_ff <= 1'b1;
    end else if (tx_load) begin
      tx_hold_full_ff <= 1'b0;
    end
  end

  // Data changes on the falling shift clock edge so the master samples on the rising one
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sck_prev_ff <= RST_LINE_LEVEL;
      tx_shift_reg_ff <= 9'h000;
      tx_left_ff <= 4'h0;
      tx_out_ff <= 1'b0;
    end else begin
      sck_prev_ff <= sck_s;
      if (!tx_slave) begin
        tx_left_ff <= 4'h0;
      end else if (tx_load) begin
        tx_shift_reg_ff <= {tx_ninth_data_ff, tx_data_reg_ff};
        tx_out_ff <= tx_data_reg_ff[0];
        tx_left_ff <= tx_nine_bit_ff ? BITS_NINE : BITS_EIGHT;
      end else if (sck_fall && tx_left_ff != 4'h0) begin
        tx_left_ff <= tx_left_ff - 4'h1;
        if (tx_left_ff != 4'h1) begin
          tx_shift_reg_ff <= {1'b0, tx_shift_reg_ff[8:1]};
          tx_out_ff <= tx_shift_reg_ff[1];
        end
      end
    end
  end

  assign tx_data_out = tx_out_ff;
  assign tx_data_oe = tx_slave;

  // ------------------------------------------------------------
  // Interrupt and wake requests
  // ------------------------------------------------------------
  assign irq_req = (rx_flag & rx_irq_enable_ff) | (tx_flag & tx_irq_enable_ff);
  assign wake_req = tx_flag & tx_irq_enable_ff & tx_slave;

endmodule : sio_serial_port

// ===== sio_serial_port_sva.sv
// Checker of bus handshake and transmit pin relations of the serial port
`timescale 1ns/1ps
module sio_serial_port_sva (
  input wire logic clk, // System clock
  input wire logic rstn, // Reset, active low
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Wait request
  input wire logic shift_clock_pin, // Shift clock
  input wire logic tx_data_out, // Transmit data
  input wire logic tx_data_oe, // Transmit enable
  input wire logic irq_req, // Interrupt request
  input wire logic wake_req // Wake request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_wr_nowait; avs_write |-> !avs_waitrequest; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_rd_wait; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read answer timing");
  property p_wait_rd; avs_waitrequest |-> avs_read; endproperty
  a_wait_rd: assert property (p_wait_rd) else $error("wait without read");
  property p_rd_hold; !avs_read |=> $stable(avs_readdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rd_upper; avs_readdata[31:8] == 24'h000000; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_oe_cause; $rose(tx_data_oe) |-> $past(avs_write); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("slave mode without write");
  property p_wake_irq; wake_req |-> irq_req; endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake without request");
  property p_wake_oe; wake_req |-> tx_data_oe; endproperty
  a_wake_oe: assert property (p_wake_oe) else $error("wake outside slave mode");
  // Data may not move once the shift clock has been high for three clocks, so never while the master samples
  property p_tx_hold; (tx_data_oe && shift_clock_pin) [*3] |-> $stable(tx_data_out); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("data moved while clock high");
  c_rx_irq: cover property ($rose(irq_req));
  c_wake: cover property ($rose(wake_req));
  c_tx_bit: cover property (tx_data_oe ##1 $fell(tx_data_out));
endmodule : sio_serial_port_sva
bind sio_serial_port sio_serial_port_sva chk_u (.clk(clk), .rstn(rstn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .shift_clock_pin(shift_clock_pin), .tx_data_out(tx_data_out), .tx_data_oe(tx_data_oe),
  .irq_req(irq_req), .wake_req(wake_req));

// ===== sio_link_model.sv
// Far side of the link: asynchronous sender and synchronous shift clock master
`timescale 1ns/1ps
module sio_link_model #(
  parameter int BIT_CLK = 128 // Clocks per bit
) (
  input wire logic clk, // System clock
  input wire logic tx_data_out, // Device transmit data
  output logic rx_line, // Receive line of the device
  output logic shift_clk // Shift clock of the device
);
  initial begin
    rx_line = 1'b1; // Idle mark
    shift_clk = 1'b0; // Stands still outside frames
  end
  task automatic send_char(input logic [8:0] d, input int nb, input logic stop_bit);
    for (int i = 0; i < nb + 2; i++) begin
      @(posedge clk);
      rx_line <= (i == 0) ? 1'b0 : (i == nb + 1) ? stop_bit : d[i-1];
      repeat (BIT_CLK - 1) @(posedge clk);
    end
    @(posedge clk);
    rx_line <= 1'b1;
  endtask : send_char
  // Own time base, so the phase against the system clock is arbitrary
  task automatic clock_word(input int nb, output logic [8:0] w);
    w = 9'h000;
    #13;
    for (int i = 0; i < nb; i++) begin
      #200 shift_clk = 1'b1;
      w[i] = tx_data_out;
      #200 shift_clk = 1'b0;
    end
  endtask : clock_word
endmodule : sio_link_model

// ===== tb_serial_rx_fifo_and_sync_slave_tx.sv
// Self-checking bench of the serial receive and slave transmit paths
`timescale 1ns/1ps
module tb_serial_rx_fifo_and_sync_slave_tx;
  import sio_pkg::*;
  logic clk, rstn, avs_read, avs_write, avs_wait, rx_line, sck, tx_out, tx_oe, irq, wake;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [7:0] rd;
  logic [8:0] d0, d1, d2, w;
  int err_total, num_checks, seed;
  sio_serial_port dut_u (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_wait), .rx_pin(rx_line), .shift_clock_pin(sck),
    .tx_data_out(tx_out), .tx_data_oe(tx_oe), .irq_req(irq), .wake_req(wake));
  sio_link_model #(.BIT_CLK(128)) link_u (.clk(clk), .tx_data_out(tx_out), .rx_line(rx_line),
    .shift_clk(sck));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Bus cycles, comparisons and expectations
  // ------------------------------------------------------------
  // Waitrequest is read at each rising edge, before the design's flops update there
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] wd);
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h000000, wd};
    do begin
      @(posedge clk);
    end while (avs_wait !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [5:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk({24'h0, rd}, {24'h0, exp});
  endtask : rc
  function automatic logic [7:0] st_exp(input logic [7:0] cfg, input logic fe, input logic ov, input logic n9);
    return {cfg[7:3], fe, ov, n9};
  endfunction : st_exp
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #3000000;
    err_total++;
    end_of_test();
  end
  initial begin
    seed = 32'hac14;
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    d0 = 9'($random(seed));
    d1 = 9'h1FF;
    d2 = 9'($random(seed));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rc(OFF_FLAGS, 8'h02);
    bus(1'b1, OFF_BAUD_LOW, 8'h01);
    bus(1'b1, OFF_IRQ_EN, 8'h01);
    bus(1'b1, OFF_RX_STATUS, 8'h90);
    rc(6'h3C, 8'h00);
    rc(OFF_RX_STATUS, 8'h90);
    link_u.send_char(d0, 8, 1'b1);
    chk(irq, 1'b1);
    link_u.send_char(d1, 8, 1'b1);
    link_u.send_char(d2, 8, 1'b1);
    rc(OFF_RX_STATUS, st_exp(8'h90, 1'b0, 1'b1, 1'b0));
    rc(OFF_RX_DATA, d0[7:0]);
    rc(OFF_FLAGS, 8'h03);
    rc(OFF_RX_DATA, d1[7:0]);
    rc(OFF_FLAGS, 8'h02);
    link_u.send_char(d2, 8, 1'b1);
    rc(OFF_FLAGS, 8'h02);
    bus(1'b1, OFF_RX_STATUS, 8'h80);
    bus(1'b1, OFF_RX_STATUS, 8'h90);
    rc(OFF_RX_STATUS, 8'h90);
    $display("overrun test done");
    link_u.send_char(d0, 8, 1'b0);
    rc(OFF_RX_STATUS, st_exp(8'h90, 1'b1, 1'b0, 1'b0));
    rc(OFF_RX_DATA, d0[7:0]);
    link_u.send_char(d2, 8, 1'b1);
    rc(OFF_RX_STATUS, 8'h90);
    rc(OFF_RX_DATA, d2[7:0]);
    bus(1'b1, OFF_RX_STATUS, 8'hD0);
    link_u.send_char(d2, 9, 1'b1);
    rc(OFF_RX_STATUS, st_exp(8'hD0, 1'b0, 1'b0, d2[8]));
    rc(OFF_RX_DATA, d2[7:0]);
    bus(1'b1, OFF_RX_STATUS, 8'hD8);
    link_u.send_char({1'b0, d0[7:0]}, 9, 1'b1);
    rc(OFF_FLAGS, 8'h02);
    link_u.send_char(d1, 9, 1'b1);
    rc(OFF_RX_STATUS, st_exp(8'hD8, 1'b0, 1'b0, 1'b1));
    rc(OFF_RX_DATA, d1[7:0]);
    bus(1'b1, OFF_RX_STATUS, 8'h90);
    bus(1'b1, OFF_BAUD_LOW, 8'h07);
    bus(1'b1, OFF_BAUD_CTRL, 8'h02);
    link_u.send_char(d2, 8, 1'b1);
    rc(OFF_RX_DATA, d2[7:0]);
    $display("framing and nine bit test done");
    bus(1'b1, OFF_RX_STATUS, 8'h80);
    bus(1'b1, OFF_IRQ_EN, 8'h02);
    bus(1'b1, OFF_TX_STATUS, 8'h30);
    @(posedge clk);
    chk(tx_oe, 1'b1);
    bus(1'b1, OFF_TX_DATA, d2[7:0]);
    bus(1'b1, OFF_TX_DATA, d0[7:0]);
    rc(OFF_FLAGS, 8'h00);
    chk(wake, 1'b0);
    link_u.clock_word(8, w);
    chk(w, {1'b0, d2[7:0]});
    repeat (8) @(posedge clk);
    chk(wake, 1'b1);
    rc(OFF_FLAGS, 8'h02);
    link_u.clock_word(8, w);
    chk(w, {1'b0, d0[7:0]});
    bus(1'b1, OFF_TX_STATUS, 8'h71);
    bus(1'b1, OFF_TX_DATA, d2[7:0]);
    link_u.clock_word(9, w);
    chk(w, {1'b1, d2[7:0]});
    $display("slave transmit test done");
    end_of_test();
  end
endmodule : tb_serial_rx_fifo_and_sync_slave_tx
